// File: design/lsd_pkg.sv
// Purpose: shared constants for the line supervision debounce and interrupt block
// Assumes: frame sync arrives as a one-cycle pulse every 125 us on clk_i
// Notes: command indices are local choices; host writes one byte per command
package lsd_pkg;
	localparam int NUM_CH = 4;
	localparam int CLK_PERIOD_NS = 40;
	localparam int FRAME_PERIOD_NS = 125000;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam logic [2:0] FRAMES_PER_TICK = 3'(TICK_PERIOD_NS / FRAME_PERIOD_NS - 1);
	localparam logic [2:0] GK_COUNT_MAX = 3'h6;
	localparam logic [2:0] GK_COUNT_MIN = 3'h0;
	localparam logic [3:0] LOOP_DEBOUNCE_RESET = 4'h8;
	localparam logic [7:0] IRQ_MASK_RESET = 8'hff;
	localparam logic DRIVER_TTL_RESET = 1'h0;
	// command indices on the host command port
	localparam logic [2:0] CMD_DEBOUNCE = 3'h0;
	localparam logic [2:0] CMD_IRQ_MASK = 3'h1;
	localparam logic [2:0] CMD_MODE = 3'h2;
	localparam logic [2:0] CMD_GK_CH01 = 3'h3;
	localparam logic [2:0] CMD_GK_CH23 = 3'h4;
	// field positions
	localparam int DEB_MUX_EN_BIT = 7;
	localparam int DEB_TIME_LSB = 0;
	localparam int MODE_TTL_BIT = 0;
	localparam int MODE_ATI_LSB = 4;
endpackage : lsd_pkg

// File: design/lsd_supervision.sv
// Purpose: four-channel loop and ground-key debounce, real-time status and interrupt
// Assumes: all inputs synchronous to clk_i; host command strobes are one-cycle pulses
// Notes: status bit 2*ch is loop status, bit 2*ch+1 is ground status
// Notes on behaviour
// - each channel filters loop input and ground input (muxed bit or aux input)
// - loop input sampled every frame sync; a change restarts that channel's counter
// - loop counter steps on 1 ms tick; status follows after programmed count
// - one loop debounce time for all channels, separate counter per channel
// - ground-key sampling period programmed separately for each channel
// - ground counter spans 0..6, stepped once per 1..15 ms sampling period
// - ground counter counts up on high sample, down on low sample
// - count 6 sets ground status, count 0 clears it, otherwise holds
// - period zero bypasses the counter, input passes straight to ground status
// - 8-bit real-time status holds loop and ground status of four channels
// - real-time status readable at any time, channel selection irrelevant
// - in GCI mode status bits also go into the upstream SC octet
// - active-low interrupt on unmasked status change or armed transmit data change
// - interrupt stays low until cleared
// - interrupt driver selectable as driven TTL or open drain
// - while interrupt pending, unmasked status bits stay frozen
// - interrupt cleared by interrupting read, mask write, or reset
// - on read-clear, differing unmasked inputs raise a new interrupt at once
// - host read/write mask register blocks individual status bits from interrupting
// - detector multiplexing enabled by bit 7 of shared debounce configuration
// - reset clears pending interrupt, masks all sources, selects open drain
// - reset sets loop debounce time to 8 ms
`timescale 1ns/100ps
module lsd_supervision (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic frame_sync_i,
	input wire logic gci_mode_i,
	input wire logic [3:0] loop_detect_input_i,
	input wire logic [3:0] aux_detect_input_i,
	input wire logic [3:0] muxed_ground_key_bit_i,
	input wire logic [3:0] tx_pcm_change_i,
	input wire logic cmd_wr_i,
	input wire logic [2:0] cmd_addr_i,
	input wire logic [7:0] cmd_wdata_i,
	input wire logic status_rd_irq_i,
	output logic [7:0] realtime_line_status_o,
	output logic [7:0] irq_mask_o,
	output logic [7:0] debounce_cfg_o,
	output logic [7:0] sc_upstream_o,
	output logic irq_n_o,
	output logic irq_oe_o
);
	typedef struct packed {
		logic [2:0] frame_cnt;
		logic [3:0] loop_smp;
		logic [3:0][3:0] loop_cnt;
		logic [3:0] loop_st;
		logic [3:0][3:0] gk_div;
		logic [3:0][2:0] gk_cnt;
		logic [3:0] gk_st;
		logic [3:0][3:0] gk_per;
		logic [3:0] loop_debounce_time;
		logic mux_en;
		logic [7:0] mask;
		logic [3:0] arm_transmit_irq;
		logic drv_ttl;
		logic [7:0] rt;
		logic pend;
		logic irq_n;
		logic irq_oe;
		logic [7:0] sc;
	} lsd_state_t;

	lsd_state_t s_r;
	lsd_state_t s_nxt;

	always_comb begin
		logic ms_tick;
		logic gk_in;
		logic [7:0] live;
		logic [7:0] unm;
		logic clr;
		logic evt;
		ms_tick = 1'b0;
		gk_in = 1'b0;
		live = 8'h00;
		unm = 8'h00;
		clr = 1'b0;
		evt = 1'b0;
		s_nxt = s_r;
		// ms tick derived from frame sync, so no frame sync means no filtering
		ms_tick = frame_sync_i && (s_r.frame_cnt == lsd_pkg::FRAMES_PER_TICK);
		if (frame_sync_i) begin
			s_nxt.frame_cnt = ms_tick ? 3'h0 : 3'(s_r.frame_cnt + 3'h1);
		end
		for (int ch = 0; ch < lsd_pkg::NUM_CH; ch++) begin
			if (frame_sync_i) begin
				if (loop_detect_input_i[ch] != s_r.loop_smp[ch]) begin
					s_nxt.loop_smp[ch] = loop_detect_input_i[ch];
					s_nxt.loop_cnt[ch] = 4'h0;
				end else if (s_r.loop_cnt[ch] >= s_r.loop_debounce_time) begin
					s_nxt.loop_st[ch] = s_r.loop_smp[ch];
				end else if (ms_tick) begin
					s_nxt.loop_cnt[ch] = 4'(s_r.loop_cnt[ch] + 4'h1);
				end
			end
			gk_in = s_r.mux_en ? muxed_ground_key_bit_i[ch] : aux_detect_input_i[ch];
			if (s_r.gk_per[ch] == 4'h0) begin
				s_nxt.gk_st[ch] = gk_in;
				s_nxt.gk_div[ch] = 4'h0;
			end else if (ms_tick) begin
				if (4'(s_r.gk_div[ch] + 4'h1) >= s_r.gk_per[ch]) begin
					s_nxt.gk_div[ch] = 4'h0;
					if (gk_in && s_r.gk_cnt[ch] != lsd_pkg::GK_COUNT_MAX) begin
						s_nxt.gk_cnt[ch] = 3'(s_r.gk_cnt[ch] + 3'h1);
					end else if (!gk_in && s_r.gk_cnt[ch] != lsd_pkg::GK_COUNT_MIN) begin
						s_nxt.gk_cnt[ch] = 3'(s_r.gk_cnt[ch] - 3'h1);
					end
					if (s_nxt.gk_cnt[ch] == lsd_pkg::GK_COUNT_MAX) begin
						s_nxt.gk_st[ch] = 1'b1;
					end else if (s_nxt.gk_cnt[ch] == lsd_pkg::GK_COUNT_MIN) begin
						s_nxt.gk_st[ch] = 1'b0;
					end
				end else begin
					s_nxt.gk_div[ch] = 4'(s_r.gk_div[ch] + 4'h1);
				end
			end
			live[2 * ch] = s_r.loop_st[ch];
			live[2 * ch + 1] = s_r.gk_st[ch];
		end
		if (cmd_wr_i) begin
			case (cmd_addr_i)
				lsd_pkg::CMD_DEBOUNCE: begin
					s_nxt.mux_en = cmd_wdata_i[lsd_pkg::DEB_MUX_EN_BIT];
					s_nxt.loop_debounce_time = cmd_wdata_i[lsd_pkg::DEB_TIME_LSB +: 4];
				end
				lsd_pkg::CMD_IRQ_MASK: begin
					s_nxt.mask = cmd_wdata_i;
					clr = 1'b1;
				end
				lsd_pkg::CMD_MODE: begin
					s_nxt.drv_ttl = cmd_wdata_i[lsd_pkg::MODE_TTL_BIT];
					s_nxt.arm_transmit_irq = cmd_wdata_i[lsd_pkg::MODE_ATI_LSB +: 4];
				end
				lsd_pkg::CMD_GK_CH01: begin
					s_nxt.gk_per[0] = cmd_wdata_i[3:0];
					s_nxt.gk_per[1] = cmd_wdata_i[7:4];
				end
				lsd_pkg::CMD_GK_CH23: begin
					s_nxt.gk_per[2] = cmd_wdata_i[3:0];
					s_nxt.gk_per[3] = cmd_wdata_i[7:4];
				end
				default: begin
				end
			endcase
		end
		if (status_rd_irq_i) begin
			clr = 1'b1;
		end
		// a clear and a fresh difference in one cycle re-raises at once, nothing lost
		unm = ~s_nxt.mask;
		evt = (|((live ^ s_r.rt) & unm)) || (|(tx_pcm_change_i & s_r.arm_transmit_irq));
		if (s_r.pend && !clr) begin
			s_nxt.rt = (s_r.rt & unm) | (live & ~unm);
		end else begin
			s_nxt.rt = live;
			s_nxt.pend = evt;
		end
		s_nxt.irq_n = !s_nxt.pend;
		s_nxt.irq_oe = s_nxt.drv_ttl || s_nxt.pend;
		s_nxt.sc = gci_mode_i ? s_nxt.rt : 8'h00;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.loop_debounce_time <= lsd_pkg::LOOP_DEBOUNCE_RESET;
			s_r.mask <= lsd_pkg::IRQ_MASK_RESET;
			s_r.drv_ttl <= lsd_pkg::DRIVER_TTL_RESET;
			s_r.irq_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// status readable at any cycle, no channel gating
	assign realtime_line_status_o = s_r.rt;
	assign irq_mask_o = s_r.mask;
	assign debounce_cfg_o = {s_r.mux_en, 3'h0, s_r.loop_debounce_time};
	assign sc_upstream_o = s_r.sc;
	assign irq_n_o = s_r.irq_n;
	assign irq_oe_o = s_r.irq_oe;
endmodule : lsd_supervision

// File: verification/lsd_line_interface_circuit_model.sv
// Purpose: detector outputs of the line interface circuits
// Assumes: levels commanded by the bench
// Notes: aux carries the inverse ground key so the mux choice shows at the status
`timescale 1ns/100ps
module lsd_line_interface_circuit_model (input wire logic clk_i, input wire logic [3:0] loop_i, input wire logic [3:0] gk_i,
	output logic [3:0] loop_o, output logic [3:0] aux_o, output logic [3:0] mux_o);
	always @(posedge clk_i) begin
		loop_o <= loop_i;
		aux_o <= ~gk_i;
		mux_o <= gk_i;
	end
endmodule : lsd_line_interface_circuit_model

// File: verification/lsd_supervision_sva.sv
// Purpose: port assertions for lsd_supervision
// Assumes: arm bits not visible here, so any transmit change may explain a falling interrupt
// Notes: reset values checked while reset is held
`timescale 1ns/100ps
module lsd_supervision_sva (input wire logic clk_i, input wire logic rst_n_i, input wire logic gci_mode_i,
	input wire logic cmd_wr_i, input wire logic [2:0] cmd_addr_i, input wire logic [7:0] cmd_wdata_i,
	input wire logic status_rd_irq_i, input wire logic [7:0] realtime_line_status_o,
	input wire logic [7:0] irq_mask_o, input wire logic [7:0] debounce_cfg_o,
	input wire logic [7:0] sc_upstream_o, input wire logic irq_n_o, input wire logic irq_oe_o,
	input wire logic [3:0] tx_pcm_change_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_irq_stays_low: assert property (!irq_n_o && !status_rd_irq_i && !cmd_wr_i |=> !irq_n_o) else $error("irq");
	a_status_frozen: assert property (!irq_n_o && !status_rd_irq_i && !cmd_wr_i |=>
		((realtime_line_status_o ^ $past(realtime_line_status_o)) & ~irq_mask_o) == 8'h00) else $error("frz");
	a_irq_has_cause: assert property ($fell(irq_n_o) |->
		((realtime_line_status_o ^ $past(realtime_line_status_o)) & ~$past(irq_mask_o)) != 8'h00
		|| $past(tx_pcm_change_i) != 4'h0) else $error("cause");
	a_mask_write: assert property (cmd_wr_i && cmd_addr_i == 3'h1 |=> irq_mask_o == $past(cmd_wdata_i)) else $error("msk");
	a_mask_clears: assert property (cmd_wr_i && cmd_addr_i == 3'h1 && cmd_wdata_i == 8'hff |=> irq_n_o) else $error("clr");
	a_cfg_write: assert property (cmd_wr_i && cmd_addr_i == 3'h0 |=>
		debounce_cfg_o == {$past(cmd_wdata_i[7]), 3'h0, $past(cmd_wdata_i[3:0])}) else $error("cfg");
	a_sc_copy: assert property (1'b1 |=> sc_upstream_o == ($past(gci_mode_i) ? realtime_line_status_o : 8'h00))
		else $error("sc");
	a_oe_when_low: assert property (!irq_n_o |-> irq_oe_o) else $error("oe");
	a_reset_vals: assert property (disable iff (1'b0) !rst_n_i |=> irq_n_o && !irq_oe_o && irq_mask_o == 8'hff
		&& debounce_cfg_o == 8'h08 && realtime_line_status_o == 8'h00) else $error("rst");
	c_irq: cover property ($fell(irq_n_o));
	c_reraise: cover property (status_rd_irq_i && !irq_n_o ##1 !irq_n_o);
	c_mux: cover property (cmd_wr_i && cmd_addr_i == 3'h0 && cmd_wdata_i[7]);
endmodule : lsd_supervision_sva
bind lsd_supervision lsd_supervision_sva u_sva (.clk_i, .rst_n_i, .gci_mode_i, .cmd_wr_i, .cmd_addr_i,
	.cmd_wdata_i, .status_rd_irq_i, .realtime_line_status_o, .irq_mask_o, .debounce_cfg_o, .sc_upstream_o,
	.irq_n_o, .irq_oe_o, .tx_pcm_change_i);

// File: verification/tb.sv
// Purpose: self-checking bench for lsd_supervision
// Assumes: frame sync every 4 clocks, so a 1 ms tick is 32 clocks
// Notes: fast frame sync keeps the run short; one armed transmit change pulse near the end
`timescale 1ns/100ps
module tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, fs = 1'b0, gci = 1'b0, wr = 1'b0, rd = 1'b0, irq_n, oe;
	logic [2:0] addr = 3'h0;
	logic [7:0] wd = 8'h00, rt, mask, cfg, sc, e, exq[$];
	logic [3:0] lp = 4'h0, gk = 4'h0, tx = 4'h0, lpo, auxo, muxo;
	logic [31:0] seed = 32'd90886;
	int error_cnt = 0, checks = 0, cyc = 0;
	lsd_supervision DUT (.clk_i, .rst_n_i, .frame_sync_i(fs), .gci_mode_i(gci), .loop_detect_input_i(lpo),
		.aux_detect_input_i(auxo), .muxed_ground_key_bit_i(muxo), .tx_pcm_change_i(tx), .cmd_wr_i(wr),
		.cmd_addr_i(addr), .cmd_wdata_i(wd), .status_rd_irq_i(rd), .realtime_line_status_o(rt),
		.irq_mask_o(mask), .debounce_cfg_o(cfg), .sc_upstream_o(sc), .irq_n_o(irq_n), .irq_oe_o(oe));
	lsd_line_interface_circuit_model u_line_interface_circuit (.clk_i, .loop_i(lp), .gk_i(gk), .loop_o(lpo), .aux_o(auxo), .mux_o(muxo));
	always #20 clk_i = ~clk_i;
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs
	task automatic final_report();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		fs <= (cyc % 4 == 3);
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one task for writes and interrupting reads keeps strobes one cycle wide
	task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		@(posedge clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : op
	always @(posedge clk_i) begin
		if (rd && exq.size() > 0) begin
			chk(rt, exq.pop_front());
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk(mask, 8'hff);
		chk(cfg, 8'h08);
		chk(8'(irq_n), 8'h01);
		op(1'b1, 3'h3, 8'h01);
		op(1'b1, 3'h4, 8'h20);
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			op(1'b1, 3'h0, {r[0], 7'h02});
			op(1'b1, 3'h1, 8'h00);
			gci <= r[1];
			lp <= seed[3:0];
			gk <= seed[7:4];
			repeat (700) @(posedge clk_i);
			op(1'b0, 3'h0, 8'h00);
			repeat (4) @(posedge clk_i);
			for (int c = 0; c < 4; c++) e[2*c +: 2] = {r[0] ? gk[c] : ~gk[c], lp[c]};
			exq.push_back(e);
			op(1'b0, 3'h0, 8'h00);
			repeat (2) @(posedge clk_i);
			chk(8'(irq_n), 8'h01);
		end
		op(1'b1, 3'h1, 8'hff);
		lp <= ~lp;
		repeat (300) @(posedge clk_i);
		for (int c = 0; c < 4; c++) e[2*c] = lp[c];
		chk(8'(irq_n), 8'h01);
		chk(rt & 8'h55, e & 8'h55);
		op(1'b1, 3'h2, 8'h01);
		@(posedge clk_i);
		chk(8'(oe), 8'h01);
		op(1'b1, 3'h2, 8'h11);
		tx <= 4'h1;
		@(posedge clk_i);
		tx <= 4'h0;
		@(posedge clk_i);
		chk(8'(irq_n), 8'h00);
		op(1'b0, 3'h0, 8'h00);
		repeat (2) @(posedge clk_i);
		chk(8'(irq_n), 8'h01);
		final_report();
	end
endmodule : tb
